// ---- logic/drive_position_monitor.sv ----
// Drive position parameters, mode handling and position supervisors
`timescale 1ns/100ps
module drive_position_monitor
    import drive_pos_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MS_CYCLES
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic obj_wr_in,
    input wire logic [15:0] obj_addr_in,
    input wire logic [31:0] obj_wdata_in,
    output logic [31:0] obj_rdata_out,
    output logic obj_ack_out,
    output logic obj_err_out,
    input wire logic obj_rd_in,
    input wire logic [7:0] mode_active_in,
    input wire logic [31:0] demand_pos_in,
    input wire logic [31:0] actual_pos_in,
    input wire logic [31:0] raw_pos_in,
    input wire logic [31:0] target_pos_in,
    input wire logic homing_done_in,
    input wire logic fault_in,
    input wire logic [15:0] fault_code_in,
    input wire logic lag_reaction_en_in,
    output logic [15:0] status_word_out,
    output drive_pos_pkg::stop_action_t stop_action_out,
    output logic history_wr_out
);
    import drive_pos_pkg::*;

    // Configuration registers
    logic [7:0] req_mode_r, req_mode_nxt;
    logic [31:0] lag_win_r, lag_win_nxt;
    logic [15:0] lag_tmo_r, lag_tmo_nxt;
    logic [31:0] tgt_win_r, tgt_win_nxt;
    logic [15:0] tgt_time_r, tgt_time_nxt;
    // Observed position registers
    logic [7:0] disp_mode_r, disp_mode_nxt;
    logic [31:0] cmd_pos_r, cmd_pos_nxt;
    logic [31:0] raw_pos_r, raw_pos_nxt;
    logic [31:0] meas_pos_r, meas_pos_nxt;
    logic [31:0] home_dem_off_r, home_dem_off_nxt;
    logic [31:0] home_act_off_r, home_act_off_nxt;
    // Bus answer
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    // Fault and history
    stop_action_t stop_r, stop_nxt;
    logic hist_r, hist_nxt;
    logic lag_flag_d_r;
    // Millisecond divider
    logic [$clog2(TICK_CYCLES)-1:0] div_r, div_nxt;
    logic ms_tick;

    logic mode_ok;
    logic [31:0] lag_dev, tgt_dev;
    logic lag_cond, tgt_cond;
    logic lag_flag, tgt_flag;

    function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a - b;
        abs_diff = d[31] ? (32'h0000_0000 - d) : d;
    endfunction

    // Divider: one-cycle tick each millisecond
    always_comb begin
        div_nxt = div_r + 1'b1;
        ms_tick = 1'b0;
        if (div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
            div_nxt = '0;
            ms_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // Register writes
    always_comb begin
        req_mode_nxt = req_mode_r;
        lag_win_nxt = lag_win_r;
        lag_tmo_nxt = lag_tmo_r;
        tgt_win_nxt = tgt_win_r;
        tgt_time_nxt = tgt_time_r;
        if (obj_wr_in) begin
            case (obj_addr_in)
                ADDR_REQ_MODE: begin
                    // Out-of-range or reserved codes are refused, value kept
                    if (($signed(obj_wdata_in[7:0]) >= $signed(MODE_AUTO_SETUP)) &&
                        ($signed(obj_wdata_in[7:0]) <= $signed(MODE_CS_TORQUE)) &&
                        (obj_wdata_in[7:0] != MODE_RESERVED)) begin
                        req_mode_nxt = obj_wdata_in[7:0]; // RL2
                    end
                end
                ADDR_LAG_WIN: lag_win_nxt = obj_wdata_in;
                ADDR_LAG_TMO: lag_tmo_nxt = obj_wdata_in[15:0]; // RL11
                ADDR_TGT_WIN: tgt_win_nxt = obj_wdata_in;
                ADDR_TGT_TIME: tgt_time_nxt = obj_wdata_in[15:0]; // RL15
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            req_mode_r <= RST_MODE;
            lag_win_r <= RST_LAG_WIN;
            lag_tmo_r <= RST_LAG_TMO;
            tgt_win_r <= RST_TGT_WIN;
            tgt_time_r <= RST_TGT_TIME;
        end else begin
            req_mode_r <= req_mode_nxt;
            lag_win_r <= lag_win_nxt;
            lag_tmo_r <= lag_tmo_nxt;
            tgt_win_r <= tgt_win_nxt;
            tgt_time_r <= tgt_time_nxt;
        end
    end

    // Position tracking; homing captures offsets so user-unit values read zero
    always_comb begin
        home_dem_off_nxt = home_dem_off_r;
        home_act_off_nxt = home_act_off_r;
        if (homing_done_in) begin
            home_dem_off_nxt = demand_pos_in; // RL6
            home_act_off_nxt = actual_pos_in; // RL6
        end
        disp_mode_nxt = mode_active_in; // RL3
        cmd_pos_nxt = demand_pos_in - home_dem_off_nxt; // RL4
        meas_pos_nxt = actual_pos_in - home_act_off_nxt;
        raw_pos_nxt = raw_pos_in; // RL5
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            home_dem_off_r <= '0;
            home_act_off_r <= '0;
            disp_mode_r <= RST_MODE;
            cmd_pos_r <= '0;
            meas_pos_r <= '0;
            raw_pos_r <= '0;
        end else begin
            home_dem_off_r <= home_dem_off_nxt;
            home_act_off_r <= home_act_off_nxt;
            disp_mode_r <= disp_mode_nxt;
            cmd_pos_r <= cmd_pos_nxt;
            meas_pos_r <= meas_pos_nxt;
            raw_pos_r <= raw_pos_nxt;
        end
    end

    // Supervisor conditions
    assign lag_dev = abs_diff(meas_pos_r, cmd_pos_r);
    assign tgt_dev = abs_diff(meas_pos_r, target_pos_in - home_act_off_r);
    assign mode_ok = (disp_mode_r == MODE_PROF_POS) || (disp_mode_r == MODE_INTERP_POS); // RL14
    assign lag_cond = (lag_win_r != WIN_OFF) && (lag_dev > lag_win_r); // RL9
    assign tgt_cond = (tgt_win_r != TGT_WIN_OFF) && (tgt_win_r != WIN_OFF) &&
                      mode_ok && (tgt_dev < tgt_win_r); // RL13

    persist_timer u_lag_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ms_tick_in(ms_tick),
        .cond_in(lag_cond),
        .limit_ms_in(lag_tmo_r),
        .flag_out(lag_flag)
    );

    persist_timer u_tgt_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ms_tick_in(ms_tick),
        .cond_in(tgt_cond),
        .limit_ms_in(tgt_time_r),
        .flag_out(tgt_flag)
    );

    always_comb begin
        status_word_out = '0; // RL16
        status_word_out[STAT_LAG_BIT] = lag_flag; // RL8
        status_word_out[STAT_TGT_BIT] = tgt_flag; // RL12
    end

    // Fault reaction and error history pulse
    always_comb begin
        stop_nxt = STOP_NONE;
        if (fault_in) begin
            case (fault_code_in)
                FAULT_COAST: stop_nxt = STOP_COAST; // RL1
                FAULT_SLOW: stop_nxt = STOP_SLOW; // RL1
                FAULT_QUICK: stop_nxt = STOP_QUICK; // RL1
                default: stop_nxt = STOP_NONE;
            endcase
        end
        // One entry per rising edge of the lag flag, not per cycle held
        hist_nxt = lag_reaction_en_in && lag_flag && !lag_flag_d_r; // RL10
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stop_r <= STOP_NONE;
            hist_r <= 1'b0;
            lag_flag_d_r <= 1'b0;
        end else begin
            stop_r <= stop_nxt;
            hist_r <= hist_nxt;
            lag_flag_d_r <= lag_flag;
        end
    end

    assign stop_action_out = stop_r;
    assign history_wr_out = hist_r;

    // Object read and write answers, one cycle after the request
    always_comb begin
        rdata_nxt = '0;
        ack_nxt = obj_rd_in || obj_wr_in;
        err_nxt = 1'b0;
        case (obj_addr_in)
            ADDR_REQ_MODE: rdata_nxt = {{24{req_mode_r[7]}}, req_mode_r}; // RL2
            ADDR_MODE_DISP: begin
                rdata_nxt = {{24{disp_mode_r[7]}}, disp_mode_r}; // RL3
                err_nxt = obj_wr_in;
            end
            ADDR_CMD_POS: begin
                rdata_nxt = cmd_pos_r; // RL4
                err_nxt = obj_wr_in;
            end
            ADDR_RAW_POS: begin
                rdata_nxt = raw_pos_r; // RL5
                err_nxt = obj_wr_in;
            end
            ADDR_MEAS_POS: begin
                rdata_nxt = meas_pos_r;
                err_nxt = obj_wr_in;
            end
            ADDR_LAG_WIN: rdata_nxt = lag_win_r;
            ADDR_LAG_TMO: rdata_nxt = {16'h0000, lag_tmo_r};
            ADDR_TGT_WIN: rdata_nxt = tgt_win_r;
            ADDR_TGT_TIME: rdata_nxt = {16'h0000, tgt_time_r};
            default: err_nxt = obj_rd_in || obj_wr_in;
        endcase
        if (!obj_rd_in) begin
            rdata_nxt = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_r <= '0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
        end
    end

    assign obj_rdata_out = rdata_r;
    assign obj_ack_out = ack_r;
    assign obj_err_out = err_r;

    a_lag_off_quiet: assert property (@(posedge clk_in) disable iff (srst_in) // RL9
        (lag_win_r == WIN_OFF) [*3] |-> !status_word_out[STAT_LAG_BIT])
        else $error("lag flag raised while monitoring off");
    a_tgt_mode_gate: assert property (@(posedge clk_in) disable iff (srst_in) // RL14
        (!mode_ok) [*3] |-> !status_word_out[STAT_TGT_BIT])
        else $error("target flag outside position modes");
    a_tgt_off_quiet: assert property (@(posedge clk_in) disable iff (srst_in) // RL13
        (tgt_win_r == TGT_WIN_OFF || tgt_win_r == WIN_OFF) [*3]
        |-> !status_word_out[STAT_TGT_BIT])
        else $error("target flag raised while monitoring off");
    a_fault_slow: assert property (@(posedge clk_in) disable iff (srst_in) // RL1
        fault_in && fault_code_in == FAULT_SLOW |=> stop_action_out == STOP_SLOW)
        else $error("slow ramp stop not issued");
    a_fault_quick: assert property (@(posedge clk_in) disable iff (srst_in) // RL1
        fault_in && fault_code_in == FAULT_QUICK |=> stop_action_out == STOP_QUICK)
        else $error("quick ramp stop not issued");
    a_homing_zero: assert property (@(posedge clk_in) disable iff (srst_in) // RL6
        homing_done_in |=> cmd_pos_r == '0 && meas_pos_r == '0)
        else $error("positions not zeroed by homing");
    a_raw_tracks: assert property (@(posedge clk_in) disable iff (srst_in) // RL5
        1'b1 |=> raw_pos_r == $past(raw_pos_in))
        else $error("raw position not tracking");
    a_disp_tracks: assert property (@(posedge clk_in) disable iff (srst_in) // RL3
        1'b1 |=> disp_mode_r == $past(mode_active_in))
        else $error("mode display not tracking");
    a_hist_needs_lag: assert property (@(posedge clk_in) disable iff (srst_in) // RL10
        history_wr_out |-> $past(lag_reaction_en_in) && $past(status_word_out[STAT_LAG_BIT]))
        else $error("history entry without lag error");
    a_mode_reserved: assert property (@(posedge clk_in) disable iff (srst_in) // RL2
        obj_wr_in && obj_addr_in == ADDR_REQ_MODE && obj_wdata_in[7:0] == MODE_RESERVED
        |=> $stable(req_mode_r))
        else $error("reserved mode accepted");

    c_lag_flag: cover property (@(posedge clk_in) $rose(status_word_out[STAT_LAG_BIT]));
    c_tgt_flag: cover property (@(posedge clk_in) $rose(status_word_out[STAT_TGT_BIT]));
    c_history: cover property (@(posedge clk_in) history_wr_out);
    c_homing: cover property (@(posedge clk_in) homing_done_in);
endmodule

// ---- inc/drive_pos_pkg.sv ----
// Constants and types for the drive position monitor
// Operation
// [RL1] On error stop motor per fault code: 0 coast, 1 slow ramp, 2 quick ramp.
// [RL2] Requested mode is signed 8-bit, -2 to 10, 5 reserved, 0 no change.
// [RL3] Read-only mode display shows the mode actually in effect, same encoding.
// [RL4] Commanded position is a read-only signed 32-bit value in user units.
// [RL5] Raw actual position is read-only signed 32-bit in encoder increments.
// [RL6] Homing zeroes commanded and measured positions, leaves raw position alone.
// [RL7] Host treats raw position as invalid when encoder resolution is zero.
// [RL8] Status bit 13 sets when deviation exceeds lag window longer than timeout.
// [RL9] Lag window all ones disables following-error monitoring completely.
// [RL10] With a lag reaction configured, an error history entry is recorded.
// [RL11] Lag timeout is an unsigned 16-bit millisecond count.
// [RL12] Status bit 10 sets when position stays within window longer than window time.
// [RL13] Target window all-ones value switches target-reached monitoring off.
// [RL14] Target test only in profile and interpolated position modes, symmetric window.
// [RL15] Target window time is an unsigned 16-bit millisecond duration.
// [RL16] Monitor status bits live in the drive status word read by the host.
// [RL17] Millisecond persistence counter restarts when condition false; flag past limit.
package drive_pos_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    localparam logic [15:0] ADDR_REQ_MODE = 16'h6060;
    localparam logic [15:0] ADDR_MODE_DISP = 16'h6061;
    localparam logic [15:0] ADDR_CMD_POS = 16'h6062;
    localparam logic [15:0] ADDR_RAW_POS = 16'h6063;
    localparam logic [15:0] ADDR_MEAS_POS = 16'h6064;
    localparam logic [15:0] ADDR_LAG_WIN = 16'h6065;
    localparam logic [15:0] ADDR_LAG_TMO = 16'h6066;
    localparam logic [15:0] ADDR_TGT_WIN = 16'h6067;
    localparam logic [15:0] ADDR_TGT_TIME = 16'h6068;

    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [31:0] RST_LAG_WIN = 32'h0000_0100;
    localparam logic [15:0] RST_LAG_TMO = 16'h0064;
    localparam logic [31:0] RST_TGT_WIN = 32'h0000_000a;
    localparam logic [15:0] RST_TGT_TIME = 16'h0064;
    localparam logic [31:0] WIN_OFF = 32'hffff_ffff;
    localparam logic [31:0] TGT_WIN_OFF = 32'h0fff_ffff;

    localparam int STAT_TGT_BIT = 10;
    localparam int STAT_LAG_BIT = 13;

    localparam logic [7:0] MODE_AUTO_SETUP = 8'hfe;
    localparam logic [7:0] MODE_CLK_DIR = 8'hff;
    localparam logic [7:0] MODE_NONE = 8'h00;
    localparam logic [7:0] MODE_PROF_POS = 8'h01;
    localparam logic [7:0] MODE_RESERVED = 8'h05;
    localparam logic [7:0] MODE_INTERP_POS = 8'h07;
    localparam logic [7:0] MODE_CS_TORQUE = 8'h0a;

    typedef enum logic [1:0] {
        STOP_COAST = 2'b00,
        STOP_SLOW = 2'b01,
        STOP_QUICK = 2'b10,
        STOP_NONE = 2'b11
    } stop_action_t;

    localparam logic [15:0] FAULT_COAST = 16'h0000;
    localparam logic [15:0] FAULT_SLOW = 16'h0001;
    localparam logic [15:0] FAULT_QUICK = 16'h0002;
endpackage

// ---- logic/persist_timer.sv ----
// Millisecond persistence timer for one position supervisor
`timescale 1ns/100ps
module persist_timer (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ms_tick_in,
    input wire logic cond_in,
    input wire logic [15:0] limit_ms_in,
    output logic flag_out
);
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    logic flag_r;
    logic flag_nxt;

    // Saturating count avoids a wrap that would drop a held flag
    always_comb begin
        cnt_nxt = cnt_r;
        flag_nxt = flag_r;
        if (!cond_in) begin
            cnt_nxt = '0; // RL17
            flag_nxt = 1'b0;
        end else begin
            if (ms_tick_in && !cnt_r[16]) begin
                cnt_nxt = cnt_r + 17'h00001;
            end
            flag_nxt = (cnt_r > {1'b0, limit_ms_in}); // RL17
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_r <= '0;
            flag_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flag_out = flag_r;

    a_flag_needs_cond: assert property (@(posedge clk_in) disable iff (srst_in) // RL17
        !cond_in |=> !flag_out)
        else $error("persistence flag set without condition");
endmodule

// ---- verif/obj_host_model.sv ----
// Host side model that issues object reads and writes to the drive
`timescale 1ns/100ps
module obj_host_model (
    input wire logic clk_in,
    output logic obj_wr_out,
    output logic obj_rd_out,
    output logic [15:0] obj_addr_out,
    output logic [31:0] obj_wdata_out,
    input wire logic [31:0] obj_rdata_in,
    input wire logic obj_ack_in,
    input wire logic obj_err_in
);
    initial begin
        obj_wr_out = 1'b0;
        obj_rd_out = 1'b0;
        obj_addr_out = 16'h0000;
        obj_wdata_out = 32'h0000_0000;
    end

    // Request is held across one rising edge; the answer is taken one cycle later
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic ack, output logic err);
        @(negedge clk_in);
        obj_wr_out = wr;
        obj_rd_out = !wr;
        obj_addr_out = addr;
        // Reads carry a junk pattern so a design that samples data on reads is caught
        obj_wdata_out = wr ? wdata : 32'ha5a5_5a5a;
        @(negedge clk_in);
        rdata = obj_rdata_in;
        ack = obj_ack_in;
        err = obj_err_in;
        obj_wr_out = 1'b0;
        obj_rd_out = 1'b0;
    endtask

    // Raw encoder count means nothing while the resolution is zero
    function automatic logic raw_valid(input logic [31:0] resolution);
        return resolution != 32'h0000_0000;
    endfunction
endmodule

// ---- verif/test_drive_position_monitor.sv ----
// Self-checking bench for the drive position monitor
`timescale 1ns/100ps
module test_drive_position_monitor;
    import drive_pos_pkg::*;
    typedef struct {
        logic wr;
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic er;
    } row_t;
    localparam logic [31:0] ENC_RES = 32'h0000_1000;
    // Shortened millisecond tick keeps the persistence tests to about a thousand cycles
    localparam int unsigned TICK_N = 200;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] mode_active_in = 8'h00;
    logic [31:0] demand_pos_in = 32'h0;
    logic [31:0] actual_pos_in = 32'h0;
    logic [31:0] raw_pos_in = 32'h0;
    logic [31:0] target_pos_in = 32'h0;
    logic homing_done_in = 1'b0;
    logic fault_in = 1'b0;
    logic [15:0] fault_code_in = 16'h0000;
    logic lag_reaction_en_in = 1'b0;
    logic obj_wr, obj_rd, obj_ack, obj_err, history_wr_out;
    logic [15:0] obj_addr, status_word_out;
    logic [31:0] obj_wdata, obj_rdata, rd_v;
    stop_action_t stop_action_out;
    logic ack_v, err_v;
    int failures = 0;
    int checks = 0;
    int hist_n = 0;
    int h0, n;
    logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h7fff};
    logic [1:0] stops [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b11};
    row_t rows [18] = '{
        '{1'b0, ADDR_REQ_MODE, 32'h0, 32'h0000_0000, 1'b0},
        '{1'b0, ADDR_MODE_DISP, 32'h0, 32'h0000_0000, 1'b0},
        '{1'b0, ADDR_LAG_WIN, 32'h0, 32'h0000_0100, 1'b0},
        '{1'b0, ADDR_LAG_TMO, 32'h0, 32'h0000_0064, 1'b0},
        '{1'b0, ADDR_TGT_WIN, 32'h0, 32'h0000_000a, 1'b0},
        '{1'b0, ADDR_TGT_TIME, 32'h0, 32'h0000_0064, 1'b0},
        '{1'b1, ADDR_MODE_DISP, 32'h5, 32'h0, 1'b1},
        '{1'b1, ADDR_CMD_POS, 32'h5, 32'h0, 1'b1},
        '{1'b1, ADDR_RAW_POS, 32'h5, 32'h0, 1'b1},
        '{1'b1, ADDR_MEAS_POS, 32'h5, 32'h0, 1'b1},
        '{1'b0, 16'h6069, 32'h0, 32'h0, 1'b1},
        '{1'b1, ADDR_REQ_MODE, 32'hfe, 32'h0, 1'b0},
        '{1'b1, ADDR_REQ_MODE, 32'h05, 32'h0, 1'b0},
        '{1'b1, ADDR_REQ_MODE, 32'h0b, 32'h0, 1'b0},
        '{1'b0, ADDR_REQ_MODE, 32'h0, 32'hffff_fffe, 1'b0},
        '{1'b1, ADDR_LAG_TMO, 32'h1234_ffff, 32'h0, 1'b0},
        '{1'b0, ADDR_LAG_TMO, 32'h0, 32'h0000_ffff, 1'b0},
        '{1'b1, ADDR_TGT_TIME, 32'h0, 32'h0, 1'b0}
    };

    always #2.5 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (history_wr_out === 1'b1) begin
            hist_n <= hist_n + 1;
        end
    end

    drive_position_monitor #(.TICK_CYCLES(TICK_N)) dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .obj_wr_in(obj_wr), .obj_addr_in(obj_addr),
        .obj_wdata_in(obj_wdata), .obj_rdata_out(obj_rdata), .obj_ack_out(obj_ack),
        .obj_err_out(obj_err), .obj_rd_in(obj_rd), .mode_active_in(mode_active_in),
        .demand_pos_in(demand_pos_in), .actual_pos_in(actual_pos_in),
        .raw_pos_in(raw_pos_in), .target_pos_in(target_pos_in),
        .homing_done_in(homing_done_in), .fault_in(fault_in), .fault_code_in(fault_code_in),
        .lag_reaction_en_in(lag_reaction_en_in), .status_word_out(status_word_out),
        .stop_action_out(stop_action_out), .history_wr_out(history_wr_out)
    );

    obj_host_model host_u (
        .clk_in(clk_in), .obj_wr_out(obj_wr), .obj_rd_out(obj_rd), .obj_addr_out(obj_addr),
        .obj_wdata_out(obj_wdata), .obj_rdata_in(obj_rdata), .obj_ack_in(obj_ack),
        .obj_err_in(obj_err)
    );

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic er);
        host_u.access(wr, a, d, rd_v, ack_v, err_v);
        cmp_bit(ack_v, 1'b1);
        cmp_bit(err_v, er);
        cmp_val(rd_v, e);
    endtask

    task automatic close_out;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run is near one thousand cycles at the shortened tick; allow about ten times that
    initial begin
        #50_000;
        failures++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        @(negedge clk_in) srst_in = 1'b0;
        cmp_val({30'h0, stop_action_out}, {30'h0, STOP_NONE});
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].a, rows[i].d, rows[i].e, rows[i].er);
        end
        $display("register table rows done");
        foreach (codes[i]) begin
            @(negedge clk_in);
            fault_in = 1'b1;
            fault_code_in = codes[i];
            repeat (2) @(negedge clk_in);
            cmp_val({30'h0, stop_action_out}, {30'h0, stops[i]});
        end
        fault_in = 1'b0;
        repeat (2) @(negedge clk_in);
        cmp_val({30'h0, stop_action_out}, {30'h0, STOP_NONE});
        $display("fault reaction done");
        xfer(1'b1, ADDR_LAG_TMO, 32'h0, 32'h0, 1'b0);
        @(negedge clk_in);
        mode_active_in = MODE_INTERP_POS;
        actual_pos_in = 32'h0000_1000;
        target_pos_in = 32'h0000_1000;
        lag_reaction_en_in = 1'b1;
        h0 = hist_n;
        n = 0;
        while (!(status_word_out[STAT_LAG_BIT] === 1'b1 && status_word_out[STAT_TGT_BIT] === 1'b1)
            && n < 2200) begin
            @(negedge clk_in);
            n++;
        end
        cmp_bit(n < 2200, 1'b1);
        repeat (4) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_2400);
        cmp_val(32'(hist_n - h0), 32'h0000_0001);
        // A non-position mode drops the target flag; profile position raises it again
        mode_active_in = 8'h08;
        repeat (3) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_2000);
        mode_active_in = MODE_PROF_POS;
        repeat (TICK_N + 10) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_2400);
        xfer(1'b1, ADDR_TGT_WIN, 32'hffff_ffff, 32'h0, 1'b0);
        repeat (2) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_2000);
        xfer(1'b1, ADDR_LAG_WIN, WIN_OFF, 32'h0, 1'b0);
        repeat (2) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_0000);
        lag_reaction_en_in = 1'b0;
        h0 = hist_n;
        xfer(1'b1, ADDR_LAG_TMO, 32'h0000_0002, 32'h0, 1'b0);
        xfer(1'b1, ADDR_LAG_WIN, RST_LAG_WIN, 32'h0, 1'b0);
        // Deviation held from here: two ticks are too few, the third must raise the flag
        repeat (2 * TICK_N - 5) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_0000);
        repeat (TICK_N + 10) @(negedge clk_in);
        cmp_val({16'h0, status_word_out}, 32'h0000_2000);
        cmp_val(32'(hist_n - h0), 32'h0000_0000);
        $display("supervisors done");
        demand_pos_in = 32'h0000_0011;
        actual_pos_in = 32'h0000_0022;
        raw_pos_in = 32'h0000_0033;
        repeat (2) @(negedge clk_in);
        xfer(1'b0, ADDR_CMD_POS, 32'h0, 32'h0000_0011, 1'b0);
        xfer(1'b0, ADDR_MEAS_POS, 32'h0, 32'h0000_0022, 1'b0);
        homing_done_in = 1'b1;
        @(negedge clk_in) homing_done_in = 1'b0;
        repeat (2) @(negedge clk_in);
        xfer(1'b0, ADDR_CMD_POS, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, ADDR_MEAS_POS, 32'h0, 32'h0, 1'b0);
        if (host_u.raw_valid(ENC_RES)) begin
            xfer(1'b0, ADDR_RAW_POS, 32'h0, 32'h0000_0033, 1'b0);
        end
        $display("homing done");
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        xfer(1'b0, ADDR_LAG_WIN, 32'h0, 32'h0000_0100, 1'b0);
        $display("second reset done");
        close_out();
    end
endmodule
